/* File: slc_host_ctrl.sv */
`timescale 1ns/100ps
module slc_host_ctrl
  import slc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // software port
  input  wire logic [3:0] sw_addr_i,
  input  wire logic [7:0] sw_wdata_i,
  input  wire logic       sw_wr_i,
  input  wire logic       sw_rd_i,
  output logic [7:0]      sw_rdata_o,
  // device configuration port
  slc_link_if.host        cfg
);
  import slc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {SLC_IDLE, SLC_WRITE, SLC_READ, SLC_CAPTURE} slc_host_e;

  typedef struct packed {
    slc_host_e  phase;      // transfer phase
    logic [2:0] target;     // device register index
    logic [7:0] data;       // data to write
    logic [7:0] rbuf;       // last read result
    logic       refused;    // sticky: order violation refused
    logic       cal_en;     // calibration enable level
    logic       link_en;    // shadow of the device link enable
    logic [9:0] b_addr;     // bus address
    logic [7:0] b_wdata;    // bus write data
    logic       b_wr;       // bus write strobe
    logic       b_rd;       // bus read strobe
    logic [7:0] sw_rdata;   // software read answer
  } slc_host_state_s;

  localparam slc_host_state_s SLC_HOST_RESET = '{
    phase: SLC_IDLE, target: 3'h0, data: SLC_ZERO8, rbuf: SLC_ZERO8,
    refused: 1'b0, cal_en: 1'b0, link_en: SLC_RST_LINK_EN[SLC_LINK_EN_BIT],
    b_addr: SLC_ADDR_BASE, b_wdata: SLC_ZERO8, b_wr: 1'b0, b_rd: 1'b0,
    sw_rdata: SLC_ZERO8
  };

  slc_host_state_s state_reg;  // registered state
  slc_host_state_s state_next; // next state

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [9:0] taddr; // target byte address
    logic       bad;   // request breaks the programming order
    logic       busy;  // a transfer is in flight
    taddr = SLC_ADDR_BASE + {7'h00, state_reg.target};
    bad   = 1'b0;
    busy  = (state_reg.phase != SLC_IDLE);
    state_next = state_reg;
    state_next.b_wr     = 1'b0;
    state_next.b_rd     = 1'b0;
    state_next.sw_rdata = SLC_ZERO8;
    // order checks on a device write
    case (taddr)
      SLC_ADDR_LINK_EN: begin
        // no enabling without calibration on
        bad = state_reg.data[SLC_LINK_EN_BIT] & ~state_reg.cal_en;
      end
      SLC_ADDR_MODE: bad = state_reg.link_en | state_reg.cal_en;
      SLC_ADDR_FPM:  bad = state_reg.link_en;
      SLC_ADDR_CTRL: bad = state_reg.link_en;
      default:       bad = 1'b0; // soft request may change any time
    endcase
    // transfer sequencer
    case (state_reg.phase)
      SLC_WRITE: begin
        state_next.phase = SLC_IDLE;
      end
      SLC_READ: begin
        state_next.phase = SLC_CAPTURE;
      end
      SLC_CAPTURE: begin
        state_next.rbuf  = cfg.rdata;
        state_next.phase = SLC_IDLE;
      end
      default: begin
      end
    endcase
    // software writes; commands while busy are dropped
    if (sw_wr_i) begin
      case (sw_addr_i)
        SLC_H_TARGET: begin
          if (sw_wdata_i[2:0] <= SLC_TGT_LAST) begin
            state_next.target = sw_wdata_i[2:0];
          end
        end
        SLC_H_DATA: state_next.data = sw_wdata_i;
        SLC_H_CMD: begin
          if (!busy && sw_wdata_i[SLC_CMD_WR_BIT]) begin
            if (bad) begin
              state_next.refused = 1'b1;
            end else begin
              state_next.b_wr    = 1'b1;
              state_next.b_addr  = taddr;
              state_next.b_wdata = state_reg.data;
              state_next.phase   = SLC_WRITE;
              if (taddr == SLC_ADDR_LINK_EN) begin
                state_next.link_en = state_reg.data[SLC_LINK_EN_BIT];
              end
            end
          end else if (!busy && sw_wdata_i[SLC_CMD_RD_BIT]) begin
            state_next.b_rd   = 1'b1;
            state_next.b_addr = taddr;
            state_next.phase  = SLC_READ;
          end
        end
        SLC_H_STATUS: begin
          if (sw_wdata_i[SLC_ST_REF_BIT]) begin
            state_next.refused = 1'b0;
          end
        end
        SLC_H_CAL: begin
          // calibration stays on until the link is off
          if (!sw_wdata_i[SLC_CAL_BIT] && state_reg.link_en) begin
            state_next.refused = 1'b1;
          end else begin
            state_next.cal_en = sw_wdata_i[SLC_CAL_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // software reads, answered next cycle
    if (sw_rd_i) begin
      case (sw_addr_i)
        SLC_H_TARGET: state_next.sw_rdata[2:0] = state_reg.target;
        SLC_H_DATA:   state_next.sw_rdata = state_reg.data;
        SLC_H_STATUS: begin
          state_next.sw_rdata[SLC_ST_BUSY_BIT] = busy;
          state_next.sw_rdata[SLC_ST_REF_BIT]  = state_reg.refused;
          state_next.sw_rdata[SLC_ST_CAL_BIT]  = state_reg.cal_en;
          state_next.sw_rdata[SLC_ST_LEN_BIT]  = state_reg.link_en;
        end
        SLC_H_RDATA:  state_next.sw_rdata = state_reg.rbuf;
        SLC_H_CAL:    state_next.sw_rdata[SLC_CAL_BIT] = state_reg.cal_en;
        default:      state_next.sw_rdata = SLC_ZERO8;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= SLC_HOST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign cfg.addr   = state_reg.b_addr;
  assign cfg.wdata  = state_reg.b_wdata;
  assign cfg.wr     = state_reg.b_wr;
  assign cfg.rd     = state_reg.b_rd;
  assign cfg.cal_en = state_reg.cal_en;
  assign sw_rdata_o = state_reg.sw_rdata;
endmodule : slc_host_ctrl

/* File: slc_pkg.sv */
package slc_pkg;
  // device register byte addresses on the configuration port
  localparam logic [9:0] SLC_ADDR_LINK_EN = 10'h200;
  localparam logic [9:0] SLC_ADDR_MODE    = 10'h201;
  localparam logic [9:0] SLC_ADDR_FPM     = 10'h202;
  localparam logic [9:0] SLC_ADDR_SYNC    = 10'h203;
  localparam logic [9:0] SLC_ADDR_CTRL    = 10'h204;
  localparam logic [9:0] SLC_ADDR_BASE    = 10'h200;
  // reset values of the device registers
  localparam logic [7:0] SLC_RST_LINK_EN  = 8'h01;
  localparam logic [7:0] SLC_RST_MODE     = 8'h02;
  localparam logic [7:0] SLC_RST_FPM      = 8'h1f;
  localparam logic [7:0] SLC_RST_SYNC     = 8'h01;
  localparam logic [7:0] SLC_RST_CTRL     = 8'h02;
  localparam logic [7:0] SLC_ZERO8        = 8'h00;
  // field positions
  localparam int SLC_LINK_EN_BIT = 0;
  localparam int SLC_FIELD5_MSB  = 4;
  localparam int SLC_SYNC_BIT    = 0;
  localparam int SLC_SEL_MSB     = 3;
  localparam int SLC_SEL_LSB     = 2;
  localparam int SLC_SFMT_BIT    = 1;
  localparam int SLC_WHITEN_BIT  = 0;
  // sync source encodings
  localparam logic [1:0] SLC_SEL_SE_PIN = 2'h0;
  localparam logic [1:0] SLC_SEL_TS_IN  = 2'h1;
  localparam logic [1:0] SLC_SEL_SOFT   = 2'h2;
  // controller register offsets on the software port
  localparam logic [3:0] SLC_H_TARGET = 4'h0;
  localparam logic [3:0] SLC_H_DATA   = 4'h1;
  localparam logic [3:0] SLC_H_CMD    = 4'h2;
  localparam logic [3:0] SLC_H_STATUS = 4'h3;
  localparam logic [3:0] SLC_H_RDATA  = 4'h4;
  localparam logic [3:0] SLC_H_CAL    = 4'h5;
  // controller field positions
  localparam int SLC_CMD_WR_BIT  = 0;
  localparam int SLC_CMD_RD_BIT  = 1;
  localparam int SLC_ST_BUSY_BIT = 0;
  localparam int SLC_ST_REF_BIT  = 1;
  localparam int SLC_ST_CAL_BIT  = 2;
  localparam int SLC_ST_LEN_BIT  = 3;
  localparam int SLC_CAL_BIT     = 0;
  localparam logic [2:0] SLC_TGT_LAST = 3'h4;
endpackage : slc_pkg

/* File: slc_link_if.sv */
`timescale 1ns/100ps
interface slc_link_if;
  logic [9:0] addr;   // register byte address
  logic [7:0] wdata;  // write data
  logic       wr;     // one-cycle write strobe
  logic       rd;     // one-cycle read strobe
  logic [7:0] rdata;  // read data, the cycle after rd
  logic       cal_en; // calibration enable level

  modport dev  (input addr, wdata, wr, rd, cal_en, output rdata);
  modport host (output addr, wdata, wr, rd, cal_en, input rdata);
endinterface : slc_link_if

/* File: slc_dev_regs.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// device end of the link control bank: five byte registers behind the
// configuration port, decoded to the link's reset, power and format controls
// the programming order is kept by the host end, not here; this end stores
// whatever reaches it, so any other master must follow the same order
// frames-per-multiframe legality against the output mode is not checked
// reserved bits are not stored, which trades read-back of junk for area
// every output is a flip-flop or a plain inversion of one, so the link
// sees no glitch from the bus decode
// both sync inputs are active low and are taken as already synchronous;
// a pin from another clock domain needs a synchroniser in front of it
////////////////////////////////////////////////////////////////////////////////
module slc_dev_regs
  import slc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // configuration port
  slc_link_if.dev         cfg,
  // sync and timing inputs
  input  wire logic       single_ended_resync_pin_low_i,
  input  wire logic       timestamp_diff_input_low_i,
  input  wire logic       timestamp_receiver_enable_i,
  input  wire logic       sysref_i,
  // link control outputs
  output logic            link_reset_o,
  output logic            serializer_power_down_o,
  output logic            link_clock_gate_o,
  output logic            lmfc_reset_o,
  output logic            sysref_align_o,
  output logic            sync_request_o,
  // link configuration outputs
  output logic [4:0]      output_mode_select_o,
  output logic [4:0]      frames_per_multiframe_less_one_o,
  output logic            sample_number_format_o,
  output logic            data_whitening_on_o
);
  import slc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic       link_enable;                    // link enable bit
    logic [4:0] output_mode_select;             // output mode field
    logic [4:0] frames_per_multiframe_less_one; // multiframe length less one
    logic       soft_resync_request_low;        // active-low soft request
    logic [1:0] sync_source;                    // sync source select
    logic       sample_number_format;           // 1 = two's complement
    logic       data_whitening_on;              // scrambler enable
    logic [7:0] rdata;                          // read answer register
    logic       sync_request;                   // combined request to link
    logic       sysref_align;                   // qualified sysref
  } slc_dev_state_s;

  // reset image; the link comes up enabled with no resync request
  localparam slc_dev_state_s SLC_DEV_RESET = '{
    link_enable:                    SLC_RST_LINK_EN[SLC_LINK_EN_BIT],
    output_mode_select:             SLC_RST_MODE[SLC_FIELD5_MSB:0],
    frames_per_multiframe_less_one: SLC_RST_FPM[SLC_FIELD5_MSB:0],
    soft_resync_request_low:        SLC_RST_SYNC[SLC_SYNC_BIT],
    sync_source:                    SLC_RST_CTRL[SLC_SEL_MSB:SLC_SEL_LSB],
    sample_number_format:           SLC_RST_CTRL[SLC_SFMT_BIT],
    data_whitening_on:              SLC_RST_CTRL[SLC_WHITEN_BIT],
    rdata:                          SLC_ZERO8,
    sync_request:                   1'b0,
    sysref_align:                   1'b0
  };

  slc_dev_state_s state_reg;  // registered state
  slc_dev_state_s state_next; // next state

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic pin_low; // selected sync pin asserted
    pin_low    = 1'b0;
    state_next = state_reg;
    state_next.rdata = SLC_ZERO8; // unmapped and idle reads give zero
    // register writes; reserved bits are not kept and read zero
    // the bus never raises write and read together, so the two decodes
    // below may both run in one pass without a priority between them
    if (cfg.wr) begin
      case (cfg.addr)
        SLC_ADDR_LINK_EN: begin
          // link on or off; the host keeps the order with calibration
          state_next.link_enable = cfg.wdata[SLC_LINK_EN_BIT];
        end
        SLC_ADDR_MODE: begin
          // output mode, taken as written
          state_next.output_mode_select = cfg.wdata[SLC_FIELD5_MSB:0];
        end
        SLC_ADDR_FPM: begin
          // multiframe length less one; legality is left to software
          state_next.frames_per_multiframe_less_one = cfg.wdata[SLC_FIELD5_MSB:0];
        end
        SLC_ADDR_SYNC: begin
          // zero asks for resync, one releases it
          state_next.soft_resync_request_low = cfg.wdata[SLC_SYNC_BIT];
        end
        SLC_ADDR_CTRL: begin
          // source, format and whitening in one byte
          state_next.sync_source          = cfg.wdata[SLC_SEL_MSB:SLC_SEL_LSB];
          state_next.sample_number_format = cfg.wdata[SLC_SFMT_BIT];
          state_next.data_whitening_on    = cfg.wdata[SLC_WHITEN_BIT];
        end
        default: begin
          // unmapped address: the write is dropped
        end
      endcase
    end
    // register reads, answered in the next cycle
    // the answer is registered so that read data never ripple from the strobe
    if (cfg.rd) begin
      case (cfg.addr)
        SLC_ADDR_LINK_EN: begin
          // enable bit only; reserved bits read zero
          state_next.rdata[SLC_LINK_EN_BIT] = state_reg.link_enable;
        end
        SLC_ADDR_MODE: begin
          // five-bit output mode
          state_next.rdata[SLC_FIELD5_MSB:0] = state_reg.output_mode_select;
        end
        SLC_ADDR_FPM: begin
          // multiframe length less one
          state_next.rdata[SLC_FIELD5_MSB:0] = state_reg.frames_per_multiframe_less_one;
        end
        SLC_ADDR_SYNC: begin
          // active-low soft request
          state_next.rdata[SLC_SYNC_BIT] = state_reg.soft_resync_request_low;
        end
        SLC_ADDR_CTRL: begin
          // source, format and whitening; the upper nibble reads zero
          state_next.rdata[SLC_SEL_MSB:SLC_SEL_LSB] = state_reg.sync_source;
          state_next.rdata[SLC_SFMT_BIT]            = state_reg.sample_number_format;
          state_next.rdata[SLC_WHITEN_BIT]          = state_reg.data_whitening_on;
        end
        default: begin
          // unmapped address answers zero
        end
      endcase
    end
    // pick the sync pin; both pins idle high and ask for resync when low
    // the timestamp input counts only with its receiver on, so an idle
    // receiver cannot hold the link in resync
    case (state_reg.sync_source)
      SLC_SEL_SE_PIN: begin
        pin_low = ~single_ended_resync_pin_low_i;
      end
      SLC_SEL_TS_IN: begin
        pin_low = ~timestamp_diff_input_low_i & timestamp_receiver_enable_i;
      end
      default: begin
        // software only, and the unused code too; a stuck pin is ignored
        pin_low = 1'b0;
      end
    endcase
    // soft request always counts, OR-ed with the pin
    // a stuck-low pin keeps the request up through any soft value
    // requests are gated off while the link is disabled: its logic is in reset
    state_next.sync_request = state_reg.link_enable &
                              (~state_reg.soft_resync_request_low | pin_low);
    // sysref cannot realign the counter while the link is off
    state_next.sysref_align = sysref_i & state_reg.link_enable;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  // asynchronous reset brings the bank to its power-on image at once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= SLC_DEV_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  // the four power and reset controls share the enable level; keeping them
  // apart lets the serializer and clock logic be retimed on their own later
  // read data are zero outside the answer cycle, so a shared bus may OR them
  assign cfg.rdata                        = state_reg.rdata;
  assign link_reset_o                     = ~state_reg.link_enable;
  assign serializer_power_down_o          = ~state_reg.link_enable;
  assign link_clock_gate_o                = ~state_reg.link_enable;
  assign lmfc_reset_o                     = ~state_reg.link_enable;
  assign sysref_align_o                   = state_reg.sysref_align;
  assign sync_request_o                   = state_reg.sync_request;
  assign output_mode_select_o             = state_reg.output_mode_select;
  assign frames_per_multiframe_less_one_o = state_reg.frames_per_multiframe_less_one;
  assign sample_number_format_o           = state_reg.sample_number_format;
  assign data_whitening_on_o              = state_reg.data_whitening_on;
endmodule : slc_dev_regs

/* File: slc_props.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// watches the config port and the link outputs of the device end
module slc_props (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // config port
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // device pins
  input wire logic       sysref_i,
  input wire logic       link_reset_o,
  input wire logic       lmfc_reset_o,
  input wire logic       sysref_align_o,
  input wire logic       sync_request_o,
  input wire logic [4:0] output_mode_select_o,
  input wire logic [4:0] frames_per_multiframe_less_one_o,
  input wire logic       data_whitening_on_o
);
  logic en_reg;   // shadow of the link enable bit
  logic soft_reg; // shadow of the soft request, low active
  // shadows follow bus writes, so properties need no long history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg   <= 1'b1;
      soft_reg <= 1'b1;
    end else if (wr) begin
      if (addr == 10'h200) en_reg <= wdata[0];
      if (addr == 10'h203) soft_reg <= wdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_link_reset: assert property (link_reset_o == !en_reg)
    else $error("link reset does not follow enable");
  chk_lmfc_held: assert property (lmfc_reset_o == !en_reg)
    else $error("multiframe counter not held");
  chk_sysref_gate: assert property (sysref_align_o == $past(sysref_i && en_reg))
    else $error("sysref alignment not gated");
  chk_enable_read: assert property (rd && addr == 10'h200 |=> rdata == {7'h00, en_reg})
    else $error("enable readback wrong");
  chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero when idle");
  chk_mode_write: assert property (wr && addr == 10'h201 |=>
    output_mode_select_o == $past(wdata[4:0]))
    else $error("mode output not written");
  chk_fpm_write: assert property (wr && addr == 10'h202 |=>
    frames_per_multiframe_less_one_o == $past(wdata[4:0]))
    else $error("multiframe length not written");
  chk_ctrl_read: assert property (rd && addr == 10'h204 |=>
    rdata[7:4] == 4'h0 && rdata[0] == data_whitening_on_o)
    else $error("control readback wrong");
  chk_sync_off: assert property (!en_reg |=> !sync_request_o)
    else $error("sync request while disabled");
  chk_soft_sync: assert property (en_reg && !soft_reg |=> sync_request_o)
    else $error("soft request ignored");
endmodule : slc_props

/* File: slc_tb.sv */
`timescale 1ns/100ps
module slc_tb;
  import slc_pkg::*;
  // one row: device target, byte written, byte read back
  typedef struct packed {
    logic [2:0] tgt;
    logic [7:0] wdat;
    logic [7:0] exp;
  } slc_row_s;
  logic       clk_i;
  logic       rst_i;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata;
  logic       sw_wr;
  logic       sw_rd;
  logic [7:0] sw_rdata;
  logic       pin_low;      // single-ended resync pin, low active
  logic       ts_low;       // timestamp input, low active
  logic       ts_en;        // timestamp receiver enable
  logic       sysref;
  logic       link_reset;
  logic       serdes_pd;
  logic       clk_gate;
  logic       lmfc_reset;
  logic       sysref_align;
  logic       sync_req;
  logic [4:0] mode;
  logic [4:0] fpm;
  logic       sfmt;
  logic       whiten;
  logic [7:0] rd_val;
  int         err_count;
  int         n_tests;
  // reserved bits must read back as zero
  // multiframe length changes only with the link off, at values kept legal
  slc_row_s rows [8] = '{'{3'h1, 8'hff, 8'h1f}, '{3'h1, 8'h02, 8'h02},
    '{3'h2, 8'he0, 8'h00}, '{3'h2, 8'h1f, 8'h1f}, '{3'h3, 8'hfe, 8'h00},
    '{3'h3, 8'h01, 8'h01}, '{3'h4, 8'hf5, 8'h05}, '{3'h4, 8'h02, 8'h02}};
  logic [7:0] rst_vals [5] = '{SLC_RST_LINK_EN, SLC_RST_MODE, SLC_RST_FPM,
    SLC_RST_SYNC, SLC_RST_CTRL};
  ////////////////////////////////////////////////////////////////
  slc_link_if link ();
  slc_host_ctrl i_slc_host_ctrl (.clk_i(clk_i), .rst_i(rst_i), .sw_addr_i(sw_addr),
    .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
    .cfg(link));
  slc_dev_regs i_slc_dev_regs (.clk_i(clk_i), .rst_i(rst_i), .cfg(link),
    .single_ended_resync_pin_low_i(pin_low), .timestamp_diff_input_low_i(ts_low),
    .timestamp_receiver_enable_i(ts_en), .sysref_i(sysref), .link_reset_o(link_reset),
    .serializer_power_down_o(serdes_pd), .link_clock_gate_o(clk_gate),
    .lmfc_reset_o(lmfc_reset), .sysref_align_o(sysref_align), .sync_request_o(sync_req),
    .output_mode_select_o(mode), .frames_per_multiframe_less_one_o(fpm),
    .sample_number_format_o(sfmt), .data_whitening_on_o(whiten));
  slc_props i_slc_props (.clk_i(clk_i), .rst_i(rst_i), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .sysref_i(sysref),
    .link_reset_o(link_reset), .lmfc_reset_o(lmfc_reset), .sysref_align_o(sysref_align),
    .sync_request_o(sync_req), .output_mode_select_o(mode),
    .frames_per_multiframe_less_one_o(fpm), .data_whitening_on_o(whiten));
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  // one-cycle strobes; a gap cycle keeps each strobe assigned once per step
  task automatic host_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk_i);
    sw_wr    <= 1'b0;
  endtask
  task automatic host_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk_i);
    sw_rd   <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // device access through the controller; busy spans at most two cycles
  task automatic dev_write(input logic [2:0] t, input logic [7:0] d);
    host_write(SLC_H_TARGET, {5'h00, t});
    host_write(SLC_H_DATA, d);
    host_write(SLC_H_CMD, 8'h01);
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic dev_read(input logic [2:0] t, output logic [7:0] d);
    host_write(SLC_H_TARGET, {5'h00, t});
    host_write(SLC_H_CMD, 8'h02);
    repeat (3) @(posedge clk_i);
    host_read(SLC_H_RDATA, d);
  endtask
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, pin_low, ts_low, ts_en, sysref} = 5'b11100;
    {sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // link must be off before mode, multiframe or control registers are touched
    dev_write(3'h0, 8'h00);
    cmp1("serdes_pd", 1'b1, serdes_pd);
    cmp1("clk_gate", 1'b1, clk_gate);
    cmp1("lmfc_reset", 1'b1, lmfc_reset);
    for (int i = 0; i < 8; i++) begin
      dev_write(rows[i].tgt, rows[i].wdat);
      dev_read(rows[i].tgt, rd_val);
      cmp8("readback", rows[i].exp, rd_val);
    end
    // stuck single-ended pin keeps the request up
    @(posedge clk_i) pin_low <= 1'b0;
    host_write(SLC_H_CAL, 8'h01);
    dev_write(3'h0, 8'h01);
    cmp1("sync_pin", 1'b1, sync_req);
    @(posedge clk_i) sysref <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 cmp1("sysref_align", 1'b1, sysref_align);
    @(posedge clk_i) sysref <= 1'b0;
    // mode change and calibration off are refused while the link runs
    dev_write(3'h1, 8'h05);
    cmp8("mode_locked", 8'h02, {3'h0, mode});
    host_write(SLC_H_CAL, 8'h00);
    host_read(SLC_H_STATUS, rd_val);
    cmp8("status", 8'h0e, rd_val);
    host_write(SLC_H_STATUS, 8'h02);
    // source two releases the stuck pin; soft request still works
    dev_write(3'h0, 8'h00);
    dev_write(3'h4, 8'h09);
    dev_write(3'h0, 8'h01);
    cmp1("sync_sel_soft", 1'b0, sync_req);
    cmp1("format", 1'b0, sfmt);
    cmp1("whiten", 1'b1, whiten);
    dev_write(3'h3, 8'h00);
    cmp1("sync_soft_on", 1'b1, sync_req);
    dev_write(3'h3, 8'h01);
    cmp1("sync_soft_off", 1'b0, sync_req);
    // timestamp source counts only with its receiver enabled
    dev_write(3'h0, 8'h00);
    dev_write(3'h4, 8'h04);
    @(posedge clk_i) ts_low <= 1'b0;
    dev_write(3'h0, 8'h01);
    cmp1("sync_ts_off", 1'b0, sync_req);
    @(posedge clk_i) ts_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 cmp1("sync_ts_on", 1'b1, sync_req);
    // second reset in mid-run restores every register
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int t = 0; t < 5; t++) begin
      dev_read(t[2:0], rd_val);
      cmp8("reset_value", rst_vals[t], rd_val);
    end
    cmp1("link_on", 1'b0, link_reset);
    cmp1("format_rst", 1'b1, sfmt);
    cmp1("whiten_rst", 1'b0, whiten);
    host_read(4'hf, rd_val);
    cmp8("unmapped", 8'h00, rd_val);
    complete_run();
  end
  // cut a hang short, some sixteen times the expected run
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    complete_run();
  end
endmodule : slc_tb
